// ===== rtl/amt_alc_if.sv
// Carrier between the register bank and the level-control step timer.
`timescale 1ns/1ps
interface amt_alc_if;
  import amt_pkg::*;
  logic [2:0] attack_code;
  logic [2:0] release_code;
  logic       attack_req;
  logic       release_req;
  logic       attack_step;
  logic       release_step;

  modport bank  (output attack_code, release_code, attack_req, release_req,
                 input attack_step, release_step);
  modport timer (input attack_code, release_code, attack_req, release_req,
                 output attack_step, release_step);
endinterface : amt_alc_if

// ===== rtl/amt_alc_step_timer.sv
// Level-control step timer: paces attack and release steps at the programmed intervals.
`timescale 1ns/1ps
module amt_alc_step_timer #(
  parameter int TICK_CYCLES = amt_pkg::TICK_CYCLES_DEF
) (
  input  wire logic   core_clk_i,
  input  wire logic   reset_i,
  amt_alc_if.timer    alc
);
  import amt_pkg::*;

  // ----------------------------------------------------------------------------
  // Microsecond enable
  // ----------------------------------------------------------------------------
  logic [TICK_W-1:0]     tick_cnt_ff;
  logic                  us_tick;
  logic [INTERVAL_W-1:0] us_cnt_ff;
  logic [INTERVAL_W-1:0] nxt_us_cnt;
  amt_alc_state_type     state_ff;
  amt_alc_state_type     nxt_state;
  logic [INTERVAL_W-1:0] attack_us;
  logic [INTERVAL_W-1:0] release_us;
  logic [INTERVAL_W-1:0] target_us;
  logic                  interval_done;

  assign us_tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk_i) begin
    if (reset_i || us_tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------------------
  // Interval selection
  // ----------------------------------------------------------------------------
  assign attack_us     = step_interval_us(ATTACK_BASE_US, alc.attack_code);
  assign release_us    = step_interval_us(RELEASE_BASE_US, alc.release_code);
  assign target_us     = (state_ff == ALC_ATTACK) ? attack_us : release_us;
  assign interval_done = us_tick && (us_cnt_ff >= target_us - INTERVAL_W'(1));

  // Attack has priority; a change of direction restarts the interval.
  always_comb begin
    nxt_state = ALC_IDLE;
    if (alc.attack_req) begin
      nxt_state = ALC_ATTACK;
    end else if (alc.release_req) begin
      nxt_state = ALC_RELEASE;
    end
  end

  always_comb begin
    nxt_us_cnt = us_cnt_ff;
    if (nxt_state != state_ff || state_ff == ALC_IDLE || interval_done) begin
      nxt_us_cnt = '0;
    end else if (us_tick) begin
      nxt_us_cnt = us_cnt_ff + INTERVAL_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_ff  <= ALC_IDLE;
      us_cnt_ff <= '0;
    end else begin
      state_ff  <= nxt_state;
      us_cnt_ff <= nxt_us_cnt;
    end
  end

  // One-cycle step pulses, only while the request still stands.
  always_comb begin
    alc.attack_step  = 1'b0;
    alc.release_step = 1'b0;
    case (state_ff)
      ALC_ATTACK:  alc.attack_step  = interval_done && nxt_state == ALC_ATTACK;
      ALC_RELEASE: alc.release_step = interval_done && nxt_state == ALC_RELEASE;
      ALC_IDLE:    ;
      default:     ;
    endcase
  end

endmodule : amt_alc_step_timer

// ===== rtl/amt_pkg.sv
// Constants and types shared by the mode and level-control timing register bank.
//
// Function
// - Edge-rate code 00 gives normal edges and is the reset code; 01, 10, 11 give slow edges.
// - Bit 3 one makes the device resume by itself after overcurrent, zero not; resets to one.
// - Bit 1 set sends the right input to both outputs, clear means no mixing; it resets to zero.
// - Bit 0 set with bit 1 clear sends the left input to both outputs, clear means no mixing; it resets to zero.
// - Release field bits 5 to 3 give 4 ms per step doubled per code up to 512 ms, reset code 101.
// - Attack field bits 2 to 0 give 32 us per step doubled per code up to 4096 us, reset code 011.
// - Every attack or release step moves the gain by one 0.5 dB unit at the selected interval.
package amt_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OUTPUT_MODE_CONTROL_ADDR  = 8'h02;
  localparam logic [7:0] LEVEL_CONTROL_TIMING_ADDR = 8'h03;
  localparam logic [7:0] WRITABLE_MASK             = 8'h3F;

  localparam int EDGE_MSB       = 5;
  localparam int EDGE_LSB       = 4;
  localparam int OC_RESUME_BIT  = 3;
  localparam int OT_RESUME_BIT  = 2;
  localparam int RIGHT_MIX_BIT  = 1;
  localparam int LEFT_MIX_BIT   = 0;
  localparam int RELEASE_MSB    = 5;
  localparam int RELEASE_LSB    = 3;
  localparam int ATTACK_MSB     = 2;
  localparam int ATTACK_LSB     = 0;

  localparam logic [7:0] OUTPUT_MODE_RESET  = 8'h0C;
  localparam logic [7:0] LEVEL_TIMING_RESET = 8'h2B;

  localparam logic [1:0] EDGE_NORMAL = 2'h0;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int US_NS           = 1000;
  localparam int TICK_CYCLES_DEF = US_NS / CLK_PERIOD_NS;
  localparam int ATTACK_BASE_US  = 32;
  localparam int RELEASE_BASE_MS = 4;
  localparam int RELEASE_BASE_US = RELEASE_BASE_MS * 1000;
  localparam int INTERVAL_W      = 20;
  localparam int TICK_W          = 16;

  // Attenuation is counted in 0.5 dB units; one step is one unit.
  localparam int          ATTEN_W    = 6;
  localparam logic [5:0]  ATTEN_STEP = 6'h01;
  localparam logic [5:0]  ATTEN_MAX  = 6'h2F;

  typedef enum logic [1:0] {ALC_IDLE, ALC_ATTACK, ALC_RELEASE} amt_alc_state_type;

  // Step interval in microseconds for a base and a three-bit doubling code.
  function automatic logic [INTERVAL_W-1:0] step_interval_us(input int base_us,
                                                             input logic [2:0] code);
    logic [INTERVAL_W-1:0] base_v;
    base_v = INTERVAL_W'(base_us);
    return base_v << code;
  endfunction : step_interval_us

endpackage : amt_pkg

// ===== rtl/amt_regs.sv
// Mode control and level-control timing register bank with its control outputs.
`timescale 1ns/1ps
module amt_regs #(
  parameter int TICK_CYCLES = amt_pkg::TICK_CYCLES_DEF
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [1:0]  edge_mode_o,
  output logic             slow_edge_o,
  input  wire logic        oc_fault_i,
  input  wire logic        ot_fault_i,
  input  wire logic        fault_clear_i,
  output logic             amp_run_o,
  output logic             left_out_from_right_o,
  output logic             right_out_from_left_o,
  input  wire logic        alc_enable_i,
  input  wire logic        alc_over_i,
  output logic [amt_pkg::ATTEN_W-1:0] alc_atten_o
);
  import amt_pkg::*;

  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  logic [7:0] output_mode_control_ff;
  logic [7:0] level_control_timing_ff;
  logic       wr_mode;
  logic       wr_timing;
  logic [7:0] wdata_masked;

  assign wr_mode      = reg_wr_i && reg_addr_i == OUTPUT_MODE_CONTROL_ADDR;
  assign wr_timing    = reg_wr_i && reg_addr_i == LEVEL_CONTROL_TIMING_ADDR;
  assign wdata_masked = reg_wdata_i & WRITABLE_MASK;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      output_mode_control_ff  <= OUTPUT_MODE_RESET;
      level_control_timing_ff <= LEVEL_TIMING_RESET;
    end else begin
      if (wr_mode) begin
        output_mode_control_ff <= wdata_masked;
      end
      if (wr_timing) begin
        level_control_timing_ff <= wdata_masked;
      end
    end
  end

  // Unmapped addresses read as zero.
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  assign nxt_rdata = (reg_addr_i == OUTPUT_MODE_CONTROL_ADDR)  ? output_mode_control_ff  :
                     (reg_addr_i == LEVEL_CONTROL_TIMING_ADDR) ? level_control_timing_ff :
                     8'h00;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata & WRITABLE_MASK;
    end
  end
  assign reg_rdata_o = rdata_ff;

  // ----------------------------------------------------------------------------
  // Edge rate and mixing
  // ----------------------------------------------------------------------------
  logic [1:0] edge_code;
  logic       right_mix;
  logic       left_mix;
  logic [1:0] edge_ff;
  logic       slow_ff;
  logic       l_from_r_ff;
  logic       r_from_l_ff;

  assign edge_code = output_mode_control_ff[EDGE_MSB:EDGE_LSB];
  assign right_mix = output_mode_control_ff[RIGHT_MIX_BIT];
  assign left_mix  = output_mode_control_ff[LEFT_MIX_BIT];

  // With both mix bits set the right input wins on both outputs.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      edge_ff     <= EDGE_NORMAL;
      slow_ff     <= 1'b0;
      l_from_r_ff <= 1'b0;
      r_from_l_ff <= 1'b0;
    end else begin
      edge_ff     <= edge_code;
      slow_ff     <= edge_code != EDGE_NORMAL;
      l_from_r_ff <= right_mix;
      r_from_l_ff <= left_mix && !right_mix;
    end
  end
  assign edge_mode_o           = edge_ff;
  assign slow_edge_o           = slow_ff;
  assign left_out_from_right_o = l_from_r_ff;
  assign right_out_from_left_o = r_from_l_ff;

  // ----------------------------------------------------------------------------
  // Fault recovery
  // ----------------------------------------------------------------------------
  logic oc_hold_ff;
  logic ot_hold_ff;
  logic nxt_oc_hold;
  logic nxt_ot_hold;
  logic oc_auto;
  logic ot_auto;

  assign oc_auto = output_mode_control_ff[OC_RESUME_BIT];
  assign ot_auto = output_mode_control_ff[OT_RESUME_BIT];

  // A standing fault always holds; once gone, release by itself or by a clear.
  assign nxt_oc_hold = oc_fault_i || (oc_hold_ff && !oc_auto && !fault_clear_i);
  assign nxt_ot_hold = ot_fault_i || (ot_hold_ff && !ot_auto && !fault_clear_i);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      oc_hold_ff <= 1'b0;
      ot_hold_ff <= 1'b0;
    end else begin
      oc_hold_ff <= nxt_oc_hold;
      ot_hold_ff <= nxt_ot_hold;
    end
  end
  assign amp_run_o = !oc_hold_ff && !ot_hold_ff;

  // ----------------------------------------------------------------------------
  // Level-control gain stepping
  // ----------------------------------------------------------------------------
  amt_alc_if alc ();
  logic [ATTEN_W-1:0] atten_ff;
  logic [ATTEN_W-1:0] nxt_atten;

  assign alc.attack_code  = level_control_timing_ff[ATTACK_MSB:ATTACK_LSB];
  assign alc.release_code = level_control_timing_ff[RELEASE_MSB:RELEASE_LSB];
  assign alc.attack_req   = alc_enable_i && alc_over_i && atten_ff != ATTEN_MAX;
  assign alc.release_req  = alc_enable_i && !alc_over_i && atten_ff != '0;

  amt_alc_step_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_amt_alc_step_timer (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .alc        (alc.timer)
  );

  assign nxt_atten = !alc_enable_i    ? '0                     :
                     alc.attack_step  ? atten_ff + ATTEN_STEP  :
                     alc.release_step ? atten_ff - ATTEN_STEP  :
                     atten_ff;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      atten_ff <= '0;
    end else begin
      atten_ff <= nxt_atten;
    end
  end
  assign alc_atten_o = atten_ff;

endmodule : amt_regs

// ===== tb/amt_host_model.sv
// Host controller model that reaches the register bank over its register port.
`timescale 1ns/1ps
module amt_host_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
  end
  // Write data is inverted once released so a stale value is never mistaken for a write.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    @(posedge core_clk_i);
    #1 d = reg_rdata_i;
  endtask : rd_reg
endmodule : amt_host_model

// ===== tb/amt_regs_monitor.sv
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ps
module amt_regs_monitor
  import amt_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] edge_mode_o,
  input wire logic       slow_edge_o,
  input wire logic       oc_fault_i,
  input wire logic       ot_fault_i,
  input wire logic       amp_run_o,
  input wire logic       left_out_from_right_o,
  input wire logic       right_out_from_left_o,
  input wire logic       alc_enable_i,
  input wire logic [5:0] alc_atten_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_mode_wr;
    reg_wr_i && reg_addr_i == OUTPUT_MODE_CONTROL_ADDR;
  endsequence
  sequence s_mix_seen;
    ##2 left_out_from_right_o == $past(reg_wdata_i[1], 2)
      && right_out_from_left_o == ($past(reg_wdata_i[0], 2) && !$past(reg_wdata_i[1], 2));
  endsequence
  property p_slow_edge; slow_edge_o == (edge_mode_o != EDGE_NORMAL); endproperty
  property p_edge_wr; s_mode_wr |-> ##2 edge_mode_o == $past(reg_wdata_i[5:4], 2); endproperty
  property p_mix_wr; s_mode_wr |-> s_mix_seen; endproperty
  property p_unmapped;
    reg_addr_i != OUTPUT_MODE_CONTROL_ADDR && reg_addr_i != LEVEL_CONTROL_TIMING_ADDR
      |=> reg_rdata_o == 8'h00;
  endproperty
  property p_top_zero; reg_rdata_o[7:6] == 2'h0; endproperty
  property p_oc_stop; $rose(oc_fault_i) |=> !amp_run_o; endproperty
  property p_ot_stop; $rose(ot_fault_i) |=> !amp_run_o; endproperty
  property p_step_one;
    alc_enable_i && $past(alc_enable_i) && alc_atten_o != $past(alc_atten_o)
      |-> 6'(alc_atten_o - $past(alc_atten_o)) == ATTEN_STEP
        || 6'($past(alc_atten_o) - alc_atten_o) == ATTEN_STEP;
  endproperty
  property p_alc_off; !alc_enable_i |=> alc_atten_o == 6'h00; endproperty
  a_slow_edge: assert property (p_slow_edge) else $error("slow edge flag wrong");
  a_edge_wr: assert property (p_edge_wr) else $error("edge code not applied");
  a_mix_wr: assert property (p_mix_wr) else $error("mix outputs wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_top_zero: assert property (p_top_zero) else $error("upper bits not zero");
  a_oc_stop: assert property (p_oc_stop) else $error("run on overcurrent");
  a_ot_stop: assert property (p_ot_stop) else $error("run on overtemperature");
  a_step_one: assert property (p_step_one) else $error("gain step not one unit");
  a_alc_off: assert property (p_alc_off) else $error("attenuation kept when off");
endmodule : amt_regs_monitor

bind amt_regs amt_regs_monitor u_amt_regs_monitor (.core_clk_i, .reset_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .edge_mode_o, .slow_edge_o, .oc_fault_i, .ot_fault_i,
  .amp_run_o, .left_out_from_right_o, .right_out_from_left_o, .alc_enable_i, .alc_atten_o);

// ===== tb/amt_regs_test.sv
// Self-checking bench for the mode and level-control timing register bank.
`timescale 1ns/1ps
module amt_regs_test;
  import amt_pkg::*;
  localparam int TICKS = 2;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] flt = 2'h0;
  logic       clr = 1'b0;
  logic       alc_en = 1'b0;
  logic       alc_ovr = 1'b0;
  logic [7:0] addr, wdata, rdata, rd;
  logic       wr, run, l_mix, r_mix, slow;
  logic [1:0] edge_m;
  logic [5:0] atten;
  int         num_errors = 0;
  int         check_count = 0;
  always #5 core_clk = ~core_clk;
  amt_regs #(.TICK_CYCLES(TICKS)) u_amt_regs (.core_clk_i(core_clk), .reset_i(reset),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata),
    .edge_mode_o(edge_m), .slow_edge_o(slow), .oc_fault_i(flt[0]), .ot_fault_i(flt[1]),
    .fault_clear_i(clr), .amp_run_o(run), .left_out_from_right_o(l_mix),
    .right_out_from_left_o(r_mix), .alc_enable_i(alc_en), .alc_over_i(alc_ovr),
    .alc_atten_o(atten));
  amt_host_model u_amt_host_model (.core_clk_i(core_clk), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic t_reset_vals();
    u_amt_host_model.rd_reg(8'h02, rd);
    check("mode_reset", 16'h000C, 16'(rd));
    u_amt_host_model.rd_reg(8'h03, rd);
    check("timing_reset", 16'h002B, 16'(rd));
    check("edge_reset", 16'h0000, 16'(edge_m));
    check("run_reset", 16'h0001, 16'(run));
    check("mix_reset", 16'h0000, 16'({l_mix, r_mix}));
    check("atten_reset", 16'h0000, 16'(atten));
  endtask : t_reset_vals
  task automatic t_reserved();
    for (int a = 2; a < 6; a++) begin
      u_amt_host_model.wr_reg(8'(a), 8'hFF);
      u_amt_host_model.rd_reg(8'(a), rd);
      check("masked_read", (a < 4) ? 16'h003F : 16'h0000, 16'(rd));
    end
  endtask : t_reserved
  task automatic t_edge();
    // Supply is taken to be above 4.0 V, so every slowed code is usable.
    for (int i = 0; i < 4; i++) begin
      u_amt_host_model.wr_reg(8'h02, {2'h0, 2'(i), 4'hC});
      settle(1);
      check("edge_mode", 16'(i), 16'(edge_m));
      check("slow_edge", 16'(i != 0), 16'(slow));
    end
  endtask : t_edge
  task automatic t_mix();
    for (int i = 0; i < 4; i++) begin
      u_amt_host_model.wr_reg(8'h02, {6'h03, 2'(i)});
      settle(1);
      check("right_to_both", 16'(i[1]), 16'(l_mix));
      check("left_to_both", 16'(i[0] && !i[1]), 16'(r_mix));
    end
  endtask : t_mix
  task automatic t_fault();
    for (int k = 0; k < 4; k++) begin
      u_amt_host_model.wr_reg(8'h02, k[1] ? 8'h00 : 8'h0C);
      flt <= 2'(1 << k[0]);
      settle(3);
      check("run_in_fault", 16'h0000, 16'(run));
      @(posedge core_clk);
      flt <= 2'h0;
      settle(3);
      check("auto_resume", 16'(!k[1]), 16'(run));
      @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      settle(2);
      check("cleared_run", 16'h0001, 16'(run));
    end
  endtask : t_fault
  task automatic step_gap(output int n);
    logic [5:0] a0;
    a0 = atten;
    n = 0;
    while (atten === a0 && n < 20000) begin
      settle(1);
      n++;
    end
  endtask : step_gap
  task automatic t_alc();
    int n;
    int e;
    logic [5:0] a0;
    for (int c = 0; c < 4; c++) begin
      u_amt_host_model.wr_reg(8'h03, (c < 3) ? 8'(c) : 8'h00);
      alc_en <= 1'b1;
      alc_ovr <= (c < 3);
      step_gap(n);
      a0 = atten;
      step_gap(n);
      e = (c < 3) ? (ATTACK_BASE_US * TICKS) << c : RELEASE_BASE_US * TICKS;
      check("step_gap", 16'(e), (n >= e - 2 && n <= e + 2) ? 16'(e) : 16'(n));
      check("step_size", 16'((c < 3) ? a0 + 6'h01 : a0 - 6'h01), 16'(atten));
    end
    @(posedge core_clk);
    alc_en <= 1'b0;
    settle(2);
    check("atten_off", 16'h0000, 16'(atten));
  endtask : t_alc
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_vals();
    t_reserved();
    t_edge();
    t_mix();
    t_fault();
    t_alc();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
endmodule : amt_regs_test
